// ---- logic/ude_endpoint.sv ----
// Purpose: device endpoint token handling and endpoint dma handler
// Assumes: packet decoding outside; tokens arrive as decoded strobes
// Notes:   buffer contents are counted, the IN byte stream passes a fifo
`timescale 1ns/100ps
// Behaviour
// - act on IN/OUT tokens only when address and endpoint match and are valid
// - IN to enabled endpoint: send data if a buffer is full, else NAK
// - non-iso IN data waits for host ACK; iso has no handshake
// - IN completion updates status and interrupt flag
// - OUT to enabled endpoint: store data if a buffer is empty, else NAK
// - non-iso OUT data answered by ACK; iso gets none
// - OUT reception updates status and interrupt flag
// - sixteen endpoints, each with ping and pong buffers
// - status read for an endpoint clears its interrupt flag
// - IN dma request while enabled and a buffer is free
// - request drops after burst length bytes, then restarts
// - IN buffer full by dma: request drops, buffer validated
// - end on count done, enable low or end strobe; IN validates partial
// - OUT dma request while enabled and a buffer holds data
// - OUT buffer fully read: request drops, buffer cleared
// - OUT termination clears buffer and disables the handler
// - only endpoints one to fourteen may use dma
module ude_endpoint
   import ude_pkg::*;
#(
   parameter int MAX_PKT = 64
) (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // configuration
   input  wire logic [6:0]           dev_addr_i,
   input  wire logic [NUM_EP-1:0]    ep_enable_i,
   input  wire logic [NUM_EP-1:0]    ep_dir_in_i,
   input  wire logic [NUM_EP-1:0]    ep_iso_i,
   // decoded token and packet strobes from serial interface engine
   input  wire logic                 tok_valid_i,
   input  wire logic [3:0]           tok_pid_i,
   input  wire logic [6:0]           tok_addr_i,
   input  wire logic [EP_W-1:0]      tok_ep_i,
   input  wire logic                 rx_data_done_i,
   input  wire logic                 rx_hsk_valid_i,
   input  wire logic [3:0]           rx_hsk_pid_i,
   input  wire logic                 tx_done_i,
   // transmit requests to serial interface engine
   output logic                      tx_data_start_o,
   output logic                      tx_hsk_start_o,
   output logic [3:0]                tx_hsk_pid_o,
   // processor buffer service
   input  wire logic                 cpu_validate_i,
   input  wire logic                 cpu_clear_i,
   input  wire logic [EP_W-1:0]      cpu_ep_i,
   input  wire logic                 status_read_i,
   output logic [NUM_EP-1:0]         device_interrupt_reg_o,
   output logic [1:0]                endpoint_status_reg_o,
   output logic                      irq_o,
   // dma configuration
   input  wire logic                 dma_handler_enable_i,
   input  wire logic [EP_W-1:0]      dma_endpoint_index_i,
   input  wire logic [PKT_W-1:0]     dma_burst_len_i,
   input  wire logic [15:0]          dma_count_i,
   output logic                      dma_handler_active_o,
   // dma pins
   input  wire logic                 dc_dma_acknowledge_i,
   input  wire logic                 transfer_end_strobe_i,
   output logic                      dc_dma_request_o,
   input  wire logic [DATA_W-1:0]    dma_wdata_i,
   output logic [DATA_W-1:0]         dma_rdata_o,
   // byte stream to serial interface engine
   output logic                      tx_byte_valid_o,
   input  wire logic                 tx_byte_ready_i,
   output logic [DATA_W-1:0]         tx_byte_o
);
   ude_sie_t               state;
   logic [NUM_EP-1:0]      full_a;
   logic [NUM_EP-1:0]      full_b;
   logic [NUM_EP-1:0]      irq_flag;
   logic [EP_W-1:0]        cur_ep;
   logic [1:0]             ack_q;
   logic                   eot_q1;
   logic                   eot_q2;
   logic                   en_q;
   logic                   dma_en;
   logic                   dma_req;
   logic [PKT_W-1:0]       burst_cnt;
   logic [PKT_W-1:0]       buf_cnt;
   logic [15:0]            total_cnt;
   logic [PKT_W-1:0]       cfg_burst;
   logic [15:0]            cfg_count;
   logic                   tok_ok;
   logic                   ep_has_data;
   logic                   ep_has_room;
   logic                   dma_ep_ok;
   logic                   dma_dir_in;
   logic                   ack_rise;
   logic                   byte_xfer;
   logic                   dma_term;
   logic                   buf_done;
   logic                   ev_in_done;
   logic                   ev_out_done;
   logic                   ev_dma_buf;
   logic                   f_in_ready;
   logic [DATA_W-1:0]      f_data;

   // count of full buffers for one endpoint
   function automatic logic [1:0] fill_of(input logic a, input logic b);
      return {a & b, a ^ b};
   endfunction : fill_of

   // token acceptance and buffer state of the addressed endpoint
   assign tok_ok = tok_valid_i && (tok_addr_i == dev_addr_i)
                   && ep_enable_i[tok_ep_i]
                   && ((tok_pid_i == PID_IN) == ep_dir_in_i[tok_ep_i]);
   assign ep_has_data = full_a[tok_ep_i] | full_b[tok_ep_i];
   assign ep_has_room = ~(full_a[tok_ep_i] & full_b[tok_ep_i]);

   // serial interface engine token machine
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state           <= ST_IDLE;
         cur_ep          <= '0;
         tx_data_start_o <= 1'b0;
         tx_hsk_start_o  <= 1'b0;
         tx_hsk_pid_o    <= PID_ACK;
      end else begin
         tx_data_start_o <= 1'b0;
         tx_hsk_start_o  <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               if (tok_ok && tok_pid_i == PID_IN) begin
                  cur_ep <= tok_ep_i;
                  if (ep_has_data) begin
                     tx_data_start_o <= 1'b1;
                     state           <= ST_TXDAT;
                  end else begin
                     tx_hsk_start_o <= 1'b1;
                     tx_hsk_pid_o   <= PID_NAK;
                     state          <= ST_HSK;
                  end
               end else if (tok_ok && tok_pid_i == PID_OUT) begin
                  cur_ep <= tok_ep_i;
                  if (ep_has_room) begin
                     state <= ST_RXDAT;
                  end else begin
                     tx_hsk_start_o <= 1'b1;
                     tx_hsk_pid_o   <= PID_NAK;
                     state          <= ST_HSK;
                  end
               end
            end
            ST_TXDAT: begin
               if (tx_done_i) begin
                  state <= ep_iso_i[cur_ep] ? ST_IDLE : ST_WACK;
               end
            end
            ST_WACK: begin
               if (rx_hsk_valid_i || tok_valid_i) begin
                  state <= ST_IDLE;
               end
            end
            ST_RXDAT: begin
               if (rx_data_done_i) begin
                  if (ep_iso_i[cur_ep]) begin
                     state <= ST_IDLE;
                  end else begin
                     tx_hsk_start_o <= 1'b1;
                     tx_hsk_pid_o   <= PID_ACK;
                     state          <= ST_HSK;
                  end
               end
            end
            ST_HSK: begin
               if (tx_done_i) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // completion events of the current transaction
   assign ev_in_done  = (state == ST_WACK && rx_hsk_valid_i && rx_hsk_pid_i == PID_ACK)
                        || (state == ST_TXDAT && tx_done_i && ep_iso_i[cur_ep]);
   assign ev_out_done = (state == ST_RXDAT && rx_data_done_i);

   // dma side: synchronise pins, decode endpoint, count bytes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q  <= 2'b00;
         eot_q1 <= 1'b0;
         eot_q2 <= 1'b0;
         en_q   <= 1'b0;
      end else begin
         ack_q  <= {ack_q[0], dc_dma_acknowledge_i};
         eot_q1 <= transfer_end_strobe_i;
         eot_q2 <= eot_q1;
         en_q   <= dma_handler_enable_i;   // fresh enable only
      end
   end
   assign dma_ep_ok  = (dma_endpoint_index_i >= DMA_EP_FIRST)
                       && (dma_endpoint_index_i <= DMA_EP_LAST);
   assign dma_dir_in = ep_dir_in_i[dma_endpoint_index_i];
   assign ack_rise   = ack_q[1] & dma_en & dma_req;
   assign byte_xfer  = ack_rise & (dma_dir_in ? f_in_ready : 1'b1);
   assign buf_done   = byte_xfer && (buf_cnt + 1'b1 == PKT_W'(MAX_PKT));
   assign dma_term   = dma_en && (!dma_handler_enable_i || eot_q2
                       || (byte_xfer && total_cnt + 1'b1 == cfg_count));
   assign ev_dma_buf = dma_en && (buf_done
                       || (dma_term && (!dma_dir_in || buf_cnt != '0)));

   // dma handler enable, configuration latch and counters
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dma_en    <= 1'b0;
         cfg_burst <= '0;
         cfg_count <= '0;
         burst_cnt <= '0;
         buf_cnt   <= '0;
         total_cnt <= '0;
      end else if (!dma_en) begin
         burst_cnt <= '0;
         buf_cnt   <= '0;
         total_cnt <= '0;
         if (dma_handler_enable_i && !en_q && dma_ep_ok) begin
            dma_en    <= 1'b1;
            cfg_burst <= dma_burst_len_i;
            cfg_count <= dma_count_i;
         end
      end else if (dma_term) begin
         dma_en <= 1'b0;
      end else if (byte_xfer) begin
         total_cnt <= total_cnt + 1'b1;
         burst_cnt <= (burst_cnt + 1'b1 == cfg_burst) ? '0 : burst_cnt + 1'b1;
         buf_cnt   <= buf_done ? '0 : buf_cnt + 1'b1;
      end
   end

   // request: free buffer for IN, held data for OUT; drop at burst end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dma_req <= 1'b0;
      end else if (!dma_en || dma_term) begin
         dma_req <= 1'b0;
      end else if (dma_req && byte_xfer
                   && (burst_cnt + 1'b1 == cfg_burst || buf_done)) begin
         dma_req <= 1'b0;
      end else if (!ack_q[1]) begin
         if (dma_dir_in) begin
            dma_req <= ~(full_a[dma_endpoint_index_i] & full_b[dma_endpoint_index_i]);
         end else begin
            dma_req <= full_a[dma_endpoint_index_i] | full_b[dma_endpoint_index_i];
         end
      end
   end

   // ping-pong buffer state: a fills first, b second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         full_a <= '0;
         full_b <= '0;
      end else begin
         for (int i = 0; i < NUM_EP; i++) begin
            logic fill;
            logic drain;
            fill  = 1'b0;
            drain = 1'b0;
            if (EP_W'(i) == cur_ep && (ev_out_done || ev_in_done)) begin
               fill  = !ep_dir_in_i[i];
               drain = ep_dir_in_i[i];
            end
            if (EP_W'(i) == cpu_ep_i) begin
               fill  = fill  | cpu_validate_i;
               drain = drain | cpu_clear_i;
            end
            if (EP_W'(i) == dma_endpoint_index_i && ev_dma_buf) begin
               fill  = fill  | dma_dir_in;
               drain = drain | !dma_dir_in;
            end
            if (fill && !drain) begin
               if (!full_a[i]) full_a[i] <= 1'b1;
               else            full_b[i] <= 1'b1;
            end else if (drain && !fill) begin
               if (full_b[i]) full_b[i] <= 1'b0;
               else           full_a[i] <= 1'b0;
            end
         end
      end
   end

   // endpoint interrupt flags; a new event beats the status-read clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_flag <= '0;
      end else begin
         for (int i = 0; i < NUM_EP; i++) begin
            if (EP_W'(i) == cur_ep && (ev_in_done || ev_out_done)) begin
               irq_flag[i] <= 1'b1;
            end else if (EP_W'(i) == cpu_ep_i && status_read_i) begin
               irq_flag[i] <= 1'b0;
            end
         end
      end
   end

   // registered status outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         device_interrupt_reg_o <= '0;
         endpoint_status_reg_o  <= 2'b00;
         irq_o                  <= 1'b0;
         dc_dma_request_o       <= 1'b0;
         dma_handler_active_o   <= 1'b0;
         dma_rdata_o            <= '0;
      end else begin
         device_interrupt_reg_o <= irq_flag;
         endpoint_status_reg_o  <= fill_of(full_a[cpu_ep_i], full_b[cpu_ep_i]);
         irq_o                  <= |irq_flag;
         dc_dma_request_o       <= dma_req & ~dma_term;
         dma_handler_active_o   <= dma_en & ~dma_term;
         dma_rdata_o            <= dma_wdata_i;
      end
   end

   // IN dma bytes pass the fifo toward the transmitter
   ude_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (byte_xfer & dma_dir_in),
      .in_ready_o  (f_in_ready),
      .in_data_i   (dma_wdata_i),
      .out_valid_o (tx_byte_valid_o),
      .out_ready_i (tx_byte_ready_i),
      .out_data_o  (f_data)
   );
   assign tx_byte_o = f_data;
endmodule : ude_endpoint

// ---- logic/ude_fifo.sv ----
// Purpose: small flip-flop fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes:   full and empty come from a count, not pointer compare
`timescale 1ns/100ps
module ude_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   // handshake terms
   assign in_ready_o  = (count != (AW+1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o  = mem[rd_ptr];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // storage write
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // pointers and fill count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop)  rd_ptr <= rd_ptr + 1'b1;
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : ude_fifo

// ---- logic/ude_pkg.sv ----
// Purpose: shared constants for the endpoint transfer and dma logic
// Assumes: 16 endpoints, 8-bit data, byte-wide dma strobes
// Notes:   pid codes are the usb token and handshake pids
package ude_pkg;
   localparam int          NUM_EP        = 16;
   localparam int          EP_W          = 4;
   localparam int          DATA_W        = 8;
   localparam int          PKT_W         = 11;
   localparam int          FIFO_DEPTH    = 4;
   localparam logic [3:0]  PID_OUT       = 4'h1;
   localparam logic [3:0]  PID_IN        = 4'h9;
   localparam logic [3:0]  PID_ACK       = 4'h2;
   localparam logic [3:0]  PID_NAK       = 4'hA;
   localparam logic [3:0]  DMA_EP_FIRST  = 4'h1;
   localparam logic [3:0]  DMA_EP_LAST   = 4'hE;
   localparam logic [6:0]  DEV_ADDR_RST  = 7'h00;
   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_TXDAT = 5'b00010,
      ST_WACK  = 5'b00100,
      ST_RXDAT = 5'b01000,
      ST_HSK   = 5'b10000
   } ude_sie_t;
endpackage : ude_pkg

// ---- test/tb.sv ----
// Purpose: self-checking bench for the endpoint transfer block
// Assumes: ep1,2,4 IN; ep3,5 OUT; ep4,5 isochronous; address 05
// Notes:   tasks start and end at a rising edge
`timescale 1ns/100ps
module tb;
   import ude_pkg::*;
   logic clk_i, rst_i, tok_valid_i, rx_data_done_i, rx_hsk_valid_i, tx_done_i;
   logic tx_data_start_o, tx_hsk_start_o, cpu_validate_i, cpu_clear_i, status_read_i, irq_o;
   logic dma_handler_enable_i, dma_handler_active_o, dc_dma_acknowledge_i;
   logic transfer_end_strobe_i, dc_dma_request_o, tx_byte_valid_o, tx_byte_ready_i;
   logic seen_d, seen_h, iq;
   logic [6:0] dev_addr_i, tok_addr_i;
   logic [3:0] tok_pid_i, rx_hsk_pid_i, tx_hsk_pid_o, hpid, tok_ep_i, cpu_ep_i;
   logic [3:0] dma_endpoint_index_i;
   logic [1:0] endpoint_status_reg_o, st;
   logic [15:0] ep_enable_i, ep_dir_in_i, ep_iso_i, device_interrupt_reg_o, fl, dma_count_i;
   logic [PKT_W-1:0] dma_burst_len_i;
   logic [7:0] dma_wdata_i, dma_rdata_o, tx_byte_o, pb, pw;
   int mismatches, checks_done, pops;

   ude_endpoint u_ude_endpoint (.clk_i, .rst_i, .dev_addr_i, .ep_enable_i, .ep_dir_in_i,
      .ep_iso_i, .tok_valid_i, .tok_pid_i, .tok_addr_i, .tok_ep_i, .rx_data_done_i,
      .rx_hsk_valid_i, .rx_hsk_pid_i, .tx_done_i, .tx_data_start_o, .tx_hsk_start_o,
      .tx_hsk_pid_o, .cpu_validate_i, .cpu_clear_i, .cpu_ep_i, .status_read_i,
      .device_interrupt_reg_o, .endpoint_status_reg_o, .irq_o, .dma_handler_enable_i,
      .dma_endpoint_index_i, .dma_burst_len_i, .dma_count_i, .dma_handler_active_o,
      .dc_dma_acknowledge_i, .transfer_end_strobe_i, .dc_dma_request_o, .dma_wdata_i,
      .dma_rdata_o, .tx_byte_valid_o, .tx_byte_ready_i, .tx_byte_o);
   ude_dma_ctrl_model #(.LAT(3)) u_ude_dma_ctrl_model (.clk_i, .rst_i,
      .dc_dma_request_i(dc_dma_request_o), .dc_dma_acknowledge_o(dc_dma_acknowledge_i),
      .wdata_o(dma_wdata_i));

   // 40 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   task check(input string nm, input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   task summarize();
      if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize

   // sample outputs n cycles, keep pulses seen and last levels
   task watch(input int n);
      seen_d = 0;
      seen_h = 0;
      repeat (n) begin
         #1;
         if (tx_data_start_o === 1'b1) seen_d = 1;
         if (tx_hsk_start_o === 1'b1) {seen_h, hpid} = {1'b1, tx_hsk_pid_o};
         {st, fl, iq} = {endpoint_status_reg_o, device_interrupt_reg_o, irq_o};
         @(posedge clk_i);
      end
   endtask : watch

   task tok(input logic [3:0] pid, input logic [3:0] ep);
      {tok_pid_i, tok_addr_i, tok_ep_i, tok_valid_i} <= {pid, 7'h05, ep, 1'b1};
      @(posedge clk_i);
      tok_valid_i <= 1'b0;
   endtask : tok

   // tx done, rx data done, host ack strobes
   task ev(input logic d, r, h);
      {tx_done_i, rx_data_done_i, rx_hsk_valid_i} <= {d, r, h};
      @(posedge clk_i);
      {tx_done_i, rx_data_done_i, rx_hsk_valid_i} <= 3'b000;
   endtask : ev

   // validate, clear, status read strobes
   task cpu(input logic v, c, r, input logic [3:0] ep);
      {cpu_validate_i, cpu_clear_i, status_read_i, cpu_ep_i} <= {v, c, r, ep};
      @(posedge clk_i);
      {cpu_validate_i, cpu_clear_i, status_read_i} <= 3'b000;
      @(posedge clk_i);
   endtask : cpu

   task wait_req(input logic v, input int n);
      for (int i = 0; i < n && dc_dma_request_o !== v; i++) @(posedge clk_i);
      check("dma request", dc_dma_request_o, v);
   endtask : wait_req

   task dma_end();
      transfer_end_strobe_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      transfer_end_strobe_i <= 1'b0;
      watch(6);
   endtask : dma_end

   task t_tokens();
      dev_addr_i <= 7'h06;
      tok(PID_IN, 4'h1);
      dev_addr_i <= 7'h05;
      watch(4);
      check("wrong address", {seen_d, seen_h}, 0);
      tok(PID_IN, 4'h6);
      watch(4);
      check("disabled ep", {seen_d, seen_h}, 0);
      tok(PID_IN, 4'h1);
      watch(4);
      check("in nak", {seen_d, seen_h, hpid}, {2'b01, PID_NAK});
      ev(1, 0, 0);
   endtask : t_tokens

   task t_in();
      cpu(1, 0, 0, 4'h1);
      cpu(1, 0, 0, 4'h1);
      watch(1);
      check("two full", st, 2);
      tok(PID_IN, 4'h1);
      watch(3);
      check("in data", {seen_d, seen_h}, 2'b10);
      ev(1, 0, 0);
      watch(3);
      check("flag before ack", fl[1], 0);
      ev(0, 0, 1);
      watch(4);
      check("flag after ack", {iq, fl[1], st}, 4'b1101);
      cpu(0, 0, 1, 4'h1);
      watch(3);
      check("flag read", fl[1], 0);
      cpu(1, 0, 0, 4'h4);
      tok(PID_IN, 4'h4);
      watch(3);
      ev(1, 0, 0);
      watch(4);
      check("iso in flag", fl[4], 1);
      cpu(0, 0, 1, 4'h4);
   endtask : t_in

   task t_out();
      cpu(0, 0, 0, 4'h3);
      for (int i = 0; i < 3; i++) begin
         tok(PID_OUT, 4'h3);
         watch(3);
         if (i < 2) check("out no nak", seen_h, 0);
         else check("out full nak", {seen_h, hpid}, {1'b1, PID_NAK});
         ev(i == 2, i < 2, 0);
         watch(3);
         if (i < 2) check("out ack", {seen_h, hpid}, {1'b1, PID_ACK});
         ev(i < 2, 0, 0);
      end
      watch(2);
      check("out flag", {fl[3], st}, 3'b110);
      cpu(0, 0, 1, 4'h3);
      cpu(0, 1, 0, 4'h3);
      cpu(0, 1, 0, 4'h3);
      tok(PID_OUT, 4'h5);
      watch(2);
      ev(0, 1, 0);
      watch(3);
      check("iso out", {seen_h, fl[5]}, 2'b01);
   endtask : t_out

   task t_dma_in();
      {cpu_ep_i, dma_endpoint_index_i, dma_burst_len_i} <= {4'h2, 4'h2, 11'h004};
      dma_handler_enable_i <= 1'b1;
      wait_req(1, 10);
      wait_req(0, 20);
      wait_req(1, 30);
      dma_end();
      check("in dma end", {dma_handler_active_o, st}, 3'b001);
      check("fifo held", tx_byte_valid_o, 1);
      dma_handler_enable_i <= 1'b0;
      tx_byte_ready_i <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         @(posedge clk_i);
         if (i > 0) check("rdata copy", dma_rdata_o, pw);
         pw = dma_wdata_i;
         if (tx_byte_valid_o === 1'b1) begin
            if (pops > 0) check("byte order", tx_byte_o, 8'(pb + 8'h01));
            pb = tx_byte_o;
            pops++;
         end
      end
      check("fifo drained", pops, FIFO_DEPTH);
   endtask : t_dma_in

   task t_dma_out();
      cpu(0, 0, 0, 4'h3);
      tok(PID_OUT, 4'h3);
      ev(0, 1, 0);
      watch(3);
      ev(1, 0, 0);
      dma_endpoint_index_i <= 4'h3;
      dma_handler_enable_i <= 1'b1;
      wait_req(1, 10);
      dma_end();
      check("out dma end", {dma_handler_active_o, st}, 0);
      dma_handler_enable_i <= 1'b0;
   endtask : t_dma_out

   task t_dma_bad();
      for (int i = 0; i < 2; i++) begin
         watch(2);
         {dma_endpoint_index_i, dma_handler_enable_i} <= {i ? 4'hF : 4'h0, 1'b1};
         watch(10);
         check("ineligible ep", {dma_handler_active_o, dc_dma_request_o}, 0);
         dma_handler_enable_i <= 1'b0;
      end
   endtask : t_dma_bad

   // main sequence
   initial begin
      {rst_i, tok_valid_i, rx_data_done_i, rx_hsk_valid_i, tx_done_i} = 5'b10000;
      {cpu_validate_i, cpu_clear_i, status_read_i, cpu_ep_i} = 7'h00;
      {dma_handler_enable_i, transfer_end_strobe_i, tx_byte_ready_i} = 3'b000;
      {dev_addr_i, tok_addr_i, tok_pid_i, tok_ep_i, rx_hsk_pid_i} = {7'h05, 7'h05, 8'h00, PID_ACK};
      {ep_enable_i, ep_dir_in_i, ep_iso_i} = {16'h003E, 16'h0016, 16'h0030};
      {dma_endpoint_index_i, dma_burst_len_i, dma_count_i} = {4'h0, 11'h004, 16'h0064};
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_tokens();
      t_in();
      t_out();
      t_dma_in();
      t_dma_out();
      t_dma_bad();
      summarize();
   end

   // watchdog: whole run needs well under 8000 cycles
   initial begin
      #200000;
      mismatches++;
      summarize();
   end
endmodule : tb

// ---- test/ude_dma_ctrl_model.sv ----
// Purpose: external dma controller answering the device request
// Assumes: bus granted LAT cycles after the request is seen
// Notes:   released data lines toggle so stale bytes never look valid
`timescale 1ns/100ps
module ude_dma_ctrl_model
   import ude_pkg::*;
#(
   parameter int LAT = 3
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        dc_dma_request_i,
   output logic             dc_dma_acknowledge_o,
   output logic [DATA_W-1:0] wdata_o
);
   int wait_c;
   // grant, stream bytes, release once request falls
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dc_dma_acknowledge_o <= 1'b0;
         wait_c               <= 0;
         wdata_o              <= 8'h00;
      end else if (!dc_dma_acknowledge_o) begin
         wdata_o <= ~wdata_o; // bus released
         wait_c  <= (dc_dma_request_i && wait_c < LAT) ? wait_c + 1 : 0;
         if (dc_dma_request_i && wait_c == LAT) dc_dma_acknowledge_o <= 1'b1;
      end else if (!dc_dma_request_i) begin
         dc_dma_acknowledge_o <= 1'b0;
      end else begin
         wdata_o <= wdata_o + 8'h01;
      end
   end
endmodule : ude_dma_ctrl_model

// ---- test/ude_endpoint_assertions.sv ----
// Purpose: port-level checks on the endpoint transfer block
// Assumes: one clock, sync active-high reset
// Notes:   bound to every ude_endpoint instance
`timescale 1ns/100ps
module ude_endpoint_chk
   import ude_pkg::*;
(
   // clock, reset, token side
   input wire logic              clk_i,
   input wire logic              rst_i,
   input wire logic [6:0]        dev_addr_i,
   input wire logic [NUM_EP-1:0] ep_enable_i,
   input wire logic              tok_valid_i,
   input wire logic [3:0]        tok_pid_i,
   input wire logic [6:0]        tok_addr_i,
   input wire logic [EP_W-1:0]   tok_ep_i,
   input wire logic              rx_data_done_i,
   input wire logic              tx_data_start_o,
   input wire logic              tx_hsk_start_o,
   input wire logic [3:0]        tx_hsk_pid_o,
   // processor side
   input wire logic [NUM_EP-1:0] device_interrupt_reg_o,
   input wire logic [1:0]        endpoint_status_reg_o,
   input wire logic              irq_o,
   // dma side
   input wire logic              dma_handler_enable_i,
   input wire logic [EP_W-1:0]   dma_endpoint_index_i,
   input wire logic              dma_handler_active_o,
   input wire logic              transfer_end_strobe_i,
   input wire logic              dc_dma_request_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // answers follow an accepted token or received data; status and irq sanity
   chk_data_token: assert property (tx_data_start_o |-> $past(tok_valid_i) &&
      $past(tok_pid_i) == PID_IN && $past(tok_addr_i) == $past(dev_addr_i))
      else $error("data start without addressed in token");
   chk_nak_token: assert property (tx_hsk_start_o && tx_hsk_pid_o == PID_NAK |->
      $past(tok_valid_i) && $past(ep_enable_i[tok_ep_i]))
      else $error("nak without token to enabled endpoint");
   chk_ack_rx: assert property (tx_hsk_start_o && tx_hsk_pid_o == PID_ACK |->
      $past(rx_data_done_i)) else $error("ack without received data");
   chk_status_range: assert property (endpoint_status_reg_o <= 2'h2)
      else $error("status beyond two buffers");
   chk_irq_rise: assert property ($rose(|device_interrupt_reg_o) |-> ##[0:1] irq_o)
      else $error("flag without irq");
   chk_irq_quiet: assert property (!(|device_interrupt_reg_o) [*2] |-> !irq_o)
      else $error("irq without flag");
   // dma handler
   chk_req_active: assert property ($rose(dc_dma_request_o) |-> $past(dma_handler_active_o))
      else $error("request while handler idle");
   chk_ep_range: assert property ($rose(dma_handler_enable_i) &&
      (dma_endpoint_index_i < DMA_EP_FIRST || dma_endpoint_index_i > DMA_EP_LAST)
      |=> !dma_handler_active_o [*3]) else $error("dma on ineligible endpoint");
   chk_enable_off: assert property ($fell(dma_handler_enable_i) |->
      ##[0:3] !dma_handler_active_o) else $error("handler kept running");
   chk_req_idle: assert property (!dma_handler_active_o [*2] |-> !dc_dma_request_o)
      else $error("request with handler off");
   chk_end_strobe: assert property ($rose(transfer_end_strobe_i) |->
      ##[1:6] !dma_handler_active_o) else $error("end strobe ignored");
endmodule : ude_endpoint_chk

bind ude_endpoint ude_endpoint_chk u_ude_endpoint_chk (.clk_i, .rst_i, .dev_addr_i, .ep_enable_i,
   .tok_valid_i, .tok_pid_i, .tok_addr_i, .tok_ep_i, .rx_data_done_i, .tx_data_start_o,
   .tx_hsk_start_o, .tx_hsk_pid_o, .device_interrupt_reg_o, .endpoint_status_reg_o, .irq_o,
   .dma_handler_enable_i, .dma_endpoint_index_i, .dma_handler_active_o,
   .transfer_end_strobe_i, .dc_dma_request_o);
